// ==== verilog/sseq_pkg.sv ====
// Shared constants, types and timing for the supply sequencing state engine
//-----------------------------------------------------------------------------
// Behaviour
// - Each driver output takes data from engine, host value or internal clock.
// - An internal 100 kHz clock is made and may drive any output.
// - Host-controlled outputs follow the host-written level directly.
// - Per-output drive mode; charge-pump mode only on outputs one to six.
// - Unprogrammed configuration is zero; outputs stay at weak pull-down default.
// - After configuration load and latch, outputs take their configured states.
// - Engine holds 63 state cells with exits, targets, timers and pattern.
// - Every state evaluates all ten supervised detector inputs.
// - Any state may target any other state.
// - Each state has sequence, fault-monitor and timeout exits.
// - Sequence and timeout delays reload on each state change, 0 to 400 ms; code takes any 16-bit tick count, up to 655.35 ms.
// - Engine-sourced output levels are fixed by the current state while it lasts.
// - A state change including cell fetch completes within 20 us.
// - Converter and secondary warnings OR into one input for all exits.
// - Host jump command forces advance via the sequence exit.
// - Timeout exit fires when its delay expires and goes to timeout target.
// - Sequence input must hold for the whole delay; any change restarts it.
// - Fault-monitor exit is an immediate wide OR of deviating selected inputs.
//-----------------------------------------------------------------------------
package sseq_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_OUT = 10;
  localparam int NUM_IN = 10;
  localparam int NUM_SEL = 11;
  localparam int NUM_CELLS = 63;
  localparam int AW = 6;
  localparam int DW = 16;
  localparam int CP_OUTS = 6;
  localparam logic [3:0] SEL_WARN = 4'ha;
  localparam logic [AW-1:0] START_CELL = 6'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK100_HZ = 100_000;
  localparam int HALF_CYC = CLK_HZ / (2 * CLK100_HZ);
  localparam int TICK_US = 10;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int DLY_MAX_MS = 400;
  localparam int DLY_MAX_TICKS = DLY_MAX_MS * 1000 / TICK_US;
  localparam int CHANGE_NS = 20_000;
  localparam int CHANGE_CYC = CHANGE_NS / (1_000_000_000 / CLK_HZ);

  // ---------------------------------------------------------------------------
  // Source and drive-mode codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SRC_ENGINE = 2'h0;
  localparam logic [1:0] SRC_HOST = 2'h1;
  localparam logic [1:0] SRC_CLOCK = 2'h2;
  localparam logic [2:0] MODE_OPEN_DRAIN = 3'h0;
  localparam logic [2:0] MODE_WEAK_UP_VDD = 3'h1;
  localparam logic [2:0] MODE_STRONG_UP_VDD = 3'h2;
  localparam logic [2:0] MODE_WEAK_UP_VP = 3'h3;
  localparam logic [2:0] MODE_STRONG_UP_VP = 3'h4;
  localparam logic [2:0] MODE_STRONG_DOWN = 3'h5;
  localparam logic [2:0] MODE_CHARGE_PUMP = 3'h6;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] src;
    logic [2:0] mode;
  } sseq_drv_cfg_t;

  typedef struct packed {
    logic [3:0] seq_sel;
    logic seq_pol;
    logic [DW-1:0] seq_dly;
    logic [AW-1:0] seq_nxt;
    logic to_en;
    logic to_warn;
    logic [DW-1:0] to_dly;
    logic [AW-1:0] to_nxt;
    logic [NUM_SEL-1:0] mon_mask;
    logic [NUM_SEL-1:0] mon_exp;
    logic [AW-1:0] mon_nxt;
    logic [NUM_OUT-1:0] pattern;
  } sseq_cell_t;

  localparam sseq_cell_t CELL_RESET = '0;

endpackage : sseq_pkg

// ==== verilog/sseq_cell_mem.sv ====
// State cell store: one write port for the loader, one registered read port
`timescale 1ns/1ps
module sseq_cell_mem
  import sseq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Loader write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire sseq_cell_t wr_data,
  // Engine read side
  input wire logic [AW-1:0] rd_addr,
  output sseq_cell_t rd_data
);

  sseq_cell_t mem [NUM_CELLS];

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Address 63 is not backed and is never written
  always_ff @(posedge sys_clk) begin
    if (wr_en && (int'(wr_addr) < NUM_CELLS)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Unbacked address reads as an all-zero cell
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= CELL_RESET;
    end else if (int'(rd_addr) < NUM_CELLS) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= CELL_RESET;
    end
  end

endmodule : sseq_cell_mem

// ==== verilog/sseq_engine.sv ====
// Supply sequencing state engine with programmable driver output data paths
`timescale 1ns/1ps
module sseq_engine
  import sseq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Supervised detector status, from pins
  input wire logic [3:0] positive_supply_input,
  input wire logic high_voltage_input,
  input wire logic [4:0] dual_function_input,
  input wire logic warn_converter,
  input wire logic warn_secondary,
  // Configuration load from nonvolatile memory
  input wire logic cell_wr_en,
  input wire logic [AW-1:0] cell_wr_addr,
  input wire sseq_cell_t cell_wr_data,
  input wire sseq_drv_cfg_t [NUM_OUT-1:0] driver_output_config,
  input wire logic cfg_load_done,
  // Host control
  input wire logic [NUM_OUT-1:0] host_level,
  input wire logic host_jump,
  // Driver outputs
  output logic [NUM_OUT-1:0] driver_output_n,
  output logic [NUM_OUT-1:0][2:0] driver_output_mode,
  output logic drv_default_q,
  // Engine status
  output logic [AW-1:0] cur_state_q,
  output logic engine_run_q
);

  typedef enum logic [1:0] {
    ENG_LOAD,
    ENG_FETCH,
    ENG_LATCH,
    ENG_RUN
  } sseq_eng_t;

  sseq_eng_t eng_q;
  sseq_cell_t rd_data;
  sseq_cell_t cell_q;
  sseq_drv_cfg_t [NUM_OUT-1:0] drv_cfg_q;
  logic [NUM_IN+1:0] sync1_q;
  logic [NUM_IN+1:0] sync2_q;
  logic [NUM_SEL-1:0] in_vec;
  logic [7:0] half_cnt_q;
  logic clk100_q;
  logic [7:0] tick_cnt_q;
  logic tick_q;
  logic [DW-1:0] seq_cnt_q;
  logic [DW-1:0] to_cnt_q;
  logic seq_cond;
  logic seq_hit;
  logic to_hit;
  logic mon_hit;
  logic [AW-1:0] nxt_d;
  logic take_d;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {warn_secondary, warn_converter, dual_function_input,
                  high_voltage_input, positive_supply_input};
      sync2_q <= sync1_q;
    end
  end

  // Warnings are synchronised one by one and only then ORed, so no pin feeds logic early
  assign in_vec = {sync2_q[NUM_IN+1] | sync2_q[NUM_IN], sync2_q[NUM_IN-1:0]};

  // ---------------------------------------------------------------------------
  // 100 kHz clock and 10 us tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      half_cnt_q <= '0;
      clk100_q <= 1'b0;
    end else if (half_cnt_q == 8'(HALF_CYC - 1)) begin
      half_cnt_q <= '0;
      clk100_q <= ~clk100_q;
    end else begin
      half_cnt_q <= half_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 8'(TICK_CYC - 1));
      if (tick_cnt_q == 8'(TICK_CYC - 1)) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Cell store
  // ---------------------------------------------------------------------------
  // Loader writes are only honoured before the engine starts
  sseq_cell_mem sseq_cell_mem_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(cell_wr_en && (eng_q == ENG_LOAD)),
    .wr_addr(cell_wr_addr),
    .wr_data(cell_wr_data),
    .rd_addr(cur_state_q),
    .rd_data(rd_data)
  );

  // ---------------------------------------------------------------------------
  // Exit conditions
  // ---------------------------------------------------------------------------
  always_comb begin
    seq_cond = 1'b0;
    if (int'(cell_q.seq_sel) < NUM_SEL) begin
      seq_cond = (in_vec[cell_q.seq_sel] == cell_q.seq_pol);
    end
    seq_hit = (seq_cond && (seq_cnt_q >= cell_q.seq_dly)) || host_jump;
    to_hit = (cell_q.to_en && (to_cnt_q >= cell_q.to_dly))
             || (cell_q.to_warn && in_vec[SEL_WARN]);
    mon_hit = |(cell_q.mon_mask & (in_vec ^ cell_q.mon_exp));
  end

  // Fault first, then timeout, then sequence
  always_comb begin
    take_d = (eng_q == ENG_RUN) && (mon_hit || to_hit || seq_hit);
    if (mon_hit) begin
      nxt_d = cell_q.mon_nxt;
    end else if (to_hit) begin
      nxt_d = cell_q.to_nxt;
    end else begin
      nxt_d = cell_q.seq_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Engine sequencing
  // ---------------------------------------------------------------------------
  // Three cycles per change, far inside the change budget
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eng_q <= ENG_LOAD;
      cur_state_q <= START_CELL;
      cell_q <= CELL_RESET;
      engine_run_q <= 1'b0;
    end else begin
      unique case (eng_q)
        ENG_LOAD: begin
          if (cfg_load_done) begin
            eng_q <= ENG_FETCH;
          end
        end
        ENG_FETCH: begin
          eng_q <= ENG_LATCH;
        end
        ENG_LATCH: begin
          cell_q <= rd_data;
          eng_q <= ENG_RUN;
          engine_run_q <= 1'b1;
        end
        ENG_RUN: begin
          if (take_d) begin
            cur_state_q <= nxt_d;
            eng_q <= ENG_FETCH;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Delay timers
  // ---------------------------------------------------------------------------
  // Counts are in 10 us ticks; counting stops at the programmed delay
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (eng_q != ENG_RUN)) begin
      seq_cnt_q <= '0;
    end else if (!seq_cond) begin
      seq_cnt_q <= '0;
    end else if (tick_q && (seq_cnt_q < cell_q.seq_dly)) begin
      seq_cnt_q <= seq_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || (eng_q != ENG_RUN)) begin
      to_cnt_q <= '0;
    end else if (tick_q && (to_cnt_q < cell_q.to_dly)) begin
      to_cnt_q <= to_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Driver configuration latch
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drv_cfg_q <= '0;
    end else if ((eng_q == ENG_LOAD) && cfg_load_done) begin
      drv_cfg_q <= driver_output_config;
    end
  end

  // ---------------------------------------------------------------------------
  // Driver outputs
  // ---------------------------------------------------------------------------
  // Pattern only updates at a latch, so levels hold for the whole state
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !engine_run_q) begin
      driver_output_n <= '0;
      drv_default_q <= 1'b1;
    end else begin
      drv_default_q <= 1'b0;
      for (int i = 0; i < NUM_OUT; i++) begin
        if (drv_cfg_q[i].src == SRC_HOST) begin
          driver_output_n[i] <= host_level[i];
        end else if (drv_cfg_q[i].src == SRC_CLOCK) begin
          driver_output_n[i] <= clk100_q;
        end else begin
          driver_output_n[i] <= cell_q.pattern[i];
        end
      end
    end
  end

  // Charge-pump code on outputs seven to ten falls back to open drain
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !engine_run_q) begin
      driver_output_mode <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if ((i >= CP_OUTS) && (drv_cfg_q[i].mode == MODE_CHARGE_PUMP)) begin
          driver_output_mode[i] <= MODE_OPEN_DRAIN;
        end else begin
          driver_output_mode[i] <= drv_cfg_q[i].mode;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_default_until_load;
    @(posedge sys_clk) disable iff (!rst_n)
    !engine_run_q |=> drv_default_q && (driver_output_n == '0);
  endproperty
  a_default_until_load: assert property (p_default_until_load)
    else $error("outputs left default before load");

  property p_no_cp_high;
    @(posedge sys_clk) disable iff (!rst_n)
    driver_output_mode[6] != MODE_CHARGE_PUMP && driver_output_mode[9] != MODE_CHARGE_PUMP;
  endproperty
  a_no_cp_high: assert property (p_no_cp_high)
    else $error("charge pump on high output");

  property p_mon_first;
    @(posedge sys_clk) disable iff (!rst_n)
    (eng_q == ENG_RUN) && mon_hit |=> (cur_state_q == $past(cell_q.mon_nxt)) && eng_q == ENG_FETCH;
  endproperty
  a_mon_first: assert property (p_mon_first)
    else $error("monitor exit not taken");

  property p_to_over_seq;
    @(posedge sys_clk) disable iff (!rst_n)
    (eng_q == ENG_RUN) && !mon_hit && to_hit |=> cur_state_q == $past(cell_q.to_nxt);
  endproperty
  a_to_over_seq: assert property (p_to_over_seq)
    else $error("timeout exit wrong target");

  property p_jump;
    @(posedge sys_clk) disable iff (!rst_n)
    (eng_q == ENG_RUN) && host_jump && !mon_hit && !to_hit
      |=> cur_state_q == $past(cell_q.seq_nxt);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump did not advance");

  property p_change_fast;
    @(posedge sys_clk) disable iff (!rst_n)
    (eng_q == ENG_RUN) && take_d |=> ##[1:2] (eng_q == ENG_RUN);
  endproperty
  a_change_fast: assert property (p_change_fast)
    else $error("state change too slow");

  property p_seq_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    (eng_q == ENG_RUN) && !seq_cond |=> seq_cnt_q == '0;
  endproperty
  a_seq_restart: assert property (p_seq_restart)
    else $error("sequence timer not restarted");

  property p_pattern_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    engine_run_q && (drv_cfg_q[0].src == SRC_ENGINE) && $stable(cell_q) ##1 $stable(cell_q)
      |-> driver_output_n[0] == cell_q.pattern[0];
  endproperty
  a_pattern_hold: assert property (p_pattern_hold)
    else $error("output 0 differs from state pattern");

  property p_host_out;
    @(posedge sys_clk) disable iff (!rst_n)
    engine_run_q && (drv_cfg_q[9].src == SRC_HOST) |=> driver_output_n[9] == $past(host_level[9]);
  endproperty
  a_host_out: assert property (p_host_out)
    else $error("host level not on output index 9");

  property p_clk_out;
    @(posedge sys_clk) disable iff (!rst_n)
    engine_run_q && (drv_cfg_q[8].src == SRC_CLOCK) |=> driver_output_n[8] == $past(clk100_q);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock not on output index 8");

  c_mon_exit: cover property (@(posedge sys_clk) (eng_q == ENG_RUN) && mon_hit);
  c_to_exit: cover property (@(posedge sys_clk) (eng_q == ENG_RUN) && to_hit && !mon_hit);
  c_seq_exit: cover property (@(posedge sys_clk) (eng_q == ENG_RUN) && seq_hit && !to_hit);
  c_jump: cover property (@(posedge sys_clk) (eng_q == ENG_RUN) && host_jump);

endmodule : sseq_engine

// ==== verification/sseq_supply_model.sv ====
// Far-side model: two regulators whose power-good detectors feed the engine
`timescale 1ns/1ps
module sseq_supply_model #(
  parameter int RISE_CYC = 50
) (
  // Clock
  input wire logic sys_clk,
  // Enables from the engine
  input wire logic [1:0] rail_enable,
  // Fault commands from the bench
  input wire logic rail_short,
  input wire logic rail_glitch,
  // Detector status
  output logic [1:0] rail_good
);
  int unsigned cnt [2];

  // ---------------------------------------------------------------------------
  // Ramp and detectors
  // ---------------------------------------------------------------------------
  // Rails drop at once on disable; a slow discharge would hide monitor latency
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!rail_enable[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < RISE_CYC) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  // Level status only, as the detectors give it
  assign rail_good = {(cnt[1] >= RISE_CYC), (cnt[0] >= RISE_CYC) && !rail_short && !rail_glitch};
endmodule : sseq_supply_model

// ==== verification/sseq_engine_test.sv ====
// Self-checking bench for the supply sequencing state engine
`timescale 1ns/1ps
module sseq_engine_test
  import sseq_pkg::*;
;
  typedef struct {
    logic vp0, dual0, warn_c, warn_s, jump, short_rail;
    int minc, maxc;
    logic [AW-1:0] st;
    logic [7:0] pat;
  } sseq_step_t;

  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic vp0 = 1'h0, dual0 = 1'h0, warn_c = 1'h0, warn_s = 1'h0;
  logic cell_wr_en = 1'h0;
  logic [AW-1:0] cell_wr_addr = '0;
  sseq_cell_t cell_wr_data = CELL_RESET;
  sseq_drv_cfg_t [NUM_OUT-1:0] drv_cfg = '0;
  logic cfg_load_done = 1'h0;
  logic [NUM_OUT-1:0] host_level = '0;
  logic host_jump = 1'h0, rail_short = 1'h0, rail_glitch = 1'h0;
  logic [1:0] rail_good;
  logic [NUM_OUT-1:0] driver_output_n;
  logic [NUM_OUT-1:0][2:0] driver_output_mode;
  logic drv_default_q, engine_run_q;
  logic [AW-1:0] cur_state_q;
  int num_errors = 0, tests_run = 0, n;
  logic lvl;
  bit stayed;
  // Output 7 asks for charge pump but must not get it
  logic [2:0] want_mode [10] = '{3'h6, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h2, 3'h5};
  // vp0 dual0 warn_c warn_s jump short min max state pattern
  sseq_step_t steps [14] = '{
    '{1, 0, 0, 0, 0, 0, 2, 6, 1, 8'h01},
    '{1, 0, 0, 0, 0, 0, 700, 1100, 2, 8'h03},
    '{1, 0, 0, 0, 0, 0, 40, 80, 62, 8'h83},
    '{1, 0, 1, 0, 0, 0, 2, 6, 5, 8'h23},
    '{1, 0, 0, 0, 0, 0, 2, 270, 62, 8'h83},
    '{1, 0, 0, 0, 1, 0, 1, 4, 4, 8'h93},
    '{1, 0, 0, 0, 0, 0, 230, 520, 62, 8'h83},
    '{0, 0, 0, 1, 0, 0, 2, 6, 3, 8'h04},
    '{0, 1, 0, 0, 0, 0, 2, 6, 0, 8'h00},
    '{1, 0, 0, 0, 0, 1, 2, 6, 1, 8'h01},
    '{1, 0, 0, 0, 0, 1, 4700, 5100, 3, 8'h04},
    '{0, 1, 0, 0, 0, 0, 2, 6, 0, 8'h00},
    '{1, 0, 0, 0, 0, 0, 2, 6, 1, 8'h01},
    '{0, 0, 0, 0, 0, 0, 2, 6, 0, 8'h00}};

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  sseq_supply_model sseq_supply_model_inst (
    .sys_clk(sys_clk),
    .rail_enable(driver_output_n[1:0]),
    .rail_short(rail_short),
    .rail_glitch(rail_glitch),
    .rail_good(rail_good)
  );

  sseq_engine sseq_engine_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .positive_supply_input({1'h0, rail_good, vp0}),
    .high_voltage_input(1'h0),
    .dual_function_input({4'h0, dual0}),
    .warn_converter(warn_c),
    .warn_secondary(warn_s),
    .cell_wr_en(cell_wr_en),
    .cell_wr_addr(cell_wr_addr),
    .cell_wr_data(cell_wr_data),
    .driver_output_config(drv_cfg),
    .cfg_load_done(cfg_load_done),
    .host_level(host_level),
    .host_jump(host_jump),
    .driver_output_n(driver_output_n),
    .driver_output_mode(driver_output_mode),
    .drv_default_q(drv_default_q),
    .cur_state_q(cur_state_q),
    .engine_run_q(engine_run_q)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH at %0t ns: %s", $time, msg);
    end
  endtask : check

  function automatic sseq_cell_t mk(input logic [3:0] sel, input logic pol, input int sdly,
      input logic [AW-1:0] snxt, input logic toen, input logic towarn, input int tdly,
      input logic [AW-1:0] tnxt, input logic [NUM_SEL-1:0] mask, input logic [NUM_SEL-1:0] ex,
      input logic [AW-1:0] mnxt, input logic [NUM_OUT-1:0] pat);
    mk = '{sel, pol, sdly[DW-1:0], snxt, toen, towarn, tdly[DW-1:0], tnxt, mask, ex, mnxt, pat};
  endfunction : mk

  task automatic write_cell(input logic [AW-1:0] a, input sseq_cell_t c);
    @(posedge sys_clk);
    cell_wr_en <= 1'h1;
    cell_wr_addr <= a;
    cell_wr_data <= c;
    @(posedge sys_clk);
    cell_wr_en <= 1'h0;
  endtask : write_cell

  task automatic wait_state(input logic [AW-1:0] st, input int maxc);
    int k;
    k = 0;
    while (cur_state_q !== st && k < maxc) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(cur_state_q === st, "state not reached in time");
    if (cur_state_q !== st) end_of_test();
  endtask : wait_state

  task automatic check_default(input string msg);
    check(driver_output_n === '0 && driver_output_mode === '0 && drv_default_q === 1'h1, msg);
    check(engine_run_q === 1'h0 && cur_state_q === START_CELL, msg);
  endtask : check_default

  // Drives one row, measures cycles to the expected state, then checks its pattern
  task automatic run_step(input sseq_step_t s, input int idx);
    int k;
    k = 0;
    @(posedge sys_clk);
    vp0 <= s.vp0;
    dual0 <= s.dual0;
    warn_c <= s.warn_c;
    warn_s <= s.warn_s;
    host_jump <= s.jump;
    rail_short <= s.short_rail;
    while (cur_state_q !== s.st && k < s.maxc) begin
      @(posedge sys_clk);
      host_jump <= 1'h0;
      #1;
      k++;
    end
    check(cur_state_q === s.st && k >= s.minc, "state change outside window");
    if (cur_state_q !== s.st) end_of_test();
    repeat (5) @(posedge sys_clk);
    #1;
    check(driver_output_n[7:0] === s.pat, "engine pattern wrong");
    $display("Step %0d done after %0d cycles", idx, k);
  endtask : run_step

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    drv_cfg[0] = '{SRC_ENGINE, MODE_CHARGE_PUMP};
    for (int i = 1; i < 7; i++) drv_cfg[i] = '{SRC_ENGINE, 3'(i - 1)};
    drv_cfg[7] = '{2'h3, MODE_CHARGE_PUMP};
    drv_cfg[8] = '{SRC_CLOCK, MODE_STRONG_UP_VDD};
    drv_cfg[9] = '{SRC_HOST, MODE_STRONG_DOWN};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    #1;
    check_default("outputs not at reset default");
    write_cell(6'd0, mk(4'h0, 1, 0, 6'd1, 0, 0, 0, 0, 0, 0, 0, 10'h000));
    write_cell(6'd1, mk(4'h1, 1, 4, 6'd2, 1, 0, 20, 6'd3, 11'h001, 11'h001, 6'd0, 10'h001));
    write_cell(6'd2, mk(4'h2, 1, 0, 6'd62, 1, 0, 20, 6'd3, 11'h003, 11'h003, 6'd0, 10'h003));
    write_cell(6'd62, mk(4'hf, 0, 0, 6'd4, 0, 1, 0, 6'd5, 11'h007, 11'h007, 6'd3, 10'h083));
    write_cell(6'd3, mk(4'h5, 1, 0, 6'd0, 0, 0, 0, 0, 0, 0, 0, 10'h004));
    write_cell(6'd4, mk(4'hf, 0, 0, 6'd62, 1, 0, 2, 6'd62, 11'h007, 11'h007, 6'd3, 10'h093));
    write_cell(6'd5, mk(4'ha, 0, 1, 6'd62, 0, 0, 0, 0, 0, 0, 0, 10'h023));
    repeat (20) @(posedge sys_clk);
    #1;
    check_default("outputs left default before load done");
    @(posedge sys_clk);
    cfg_load_done <= 1'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(engine_run_q === 1'h0, "engine ran early");
    @(posedge sys_clk);
    #1;
    check(engine_run_q === 1'h1 && drv_default_q === 1'h1, "start timing wrong");
    @(posedge sys_clk);
    #1;
    check(drv_default_q === 1'h0 && driver_output_n[7:0] === 8'h00, "start not seen");
    for (int i = 0; i < NUM_OUT; i++) check(driver_output_mode[i] === want_mode[i], "mode");
    $display("Start test done");
    // A late write must be ignored; cell 0 is re-entered below with its old pattern
    write_cell(6'd0, mk(4'h0, 1, 0, 6'd1, 0, 0, 0, 0, 0, 0, 0, 10'h0ff));
    for (int i = 0; i < 14; i++) run_step(steps[i], i);
    @(posedge sys_clk);
    vp0 <= 1'h1;
    wait_state(6'd1, 10);
    repeat (460) @(posedge sys_clk);
    rail_glitch <= 1'h1;
    repeat (10) @(posedge sys_clk);
    rail_glitch <= 1'h0;
    stayed = 1'b1;
    repeat (700) begin
      @(posedge sys_clk);
      #1;
      stayed &= (cur_state_q === 6'd1);
    end
    check(stayed, "sequence delay not restarted");
    wait_state(6'd2, 400);
    wait_state(6'd62, 100);
    $display("Restart test done");
    @(posedge sys_clk);
    host_level <= 10'h3ff;
    repeat (3) @(posedge sys_clk);
    #1;
    check(driver_output_n[9] === 1'h1 && driver_output_n[7:0] === 8'h83, "host high");
    @(posedge sys_clk);
    host_level <= 10'h000;
    repeat (3) @(posedge sys_clk);
    #1;
    check(driver_output_n[9] === 1'h0, "host low not routed");
    for (int k = 0; k < 3; k++) begin
      lvl = driver_output_n[8];
      n = 0;
      while (driver_output_n[8] === lvl && n < 300) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      if (k > 0) check(n == HALF_CYC, "clock half period wrong");
    end
    $display("Source test done");
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    check_default("mid-run reset not honoured");
    $display("Reset test done");
    end_of_test();
  end
endmodule : sseq_engine_test
